// ---- rtl/flash_bus_cycle.sv ----
/*
  One host bus cycle on the flash pins: a write with a clean strobe
  pulse or a read that samples the data pins.
  Assumes the data input has already passed a two-stage synchroniser.
*/
`timescale 1ns/1ns
module flash_bus_cycle
  import flash_host_pkg::*;
(
  // Clock and reset
  input  wire logic                ref_clk,
  input  wire logic                rst,
  // Request side
  input  wire logic                req_wr,
  input  wire logic                req_rd,
  input  wire logic [ADDR_W-1:0]   req_addr,
  input  wire logic [DATA_W-1:0]   req_data,
  output logic                     cyc_done,
  output logic [DATA_W-1:0]        rd_data,
  // Flash pins
  output logic [ADDR_W-1:0]        addr_q,
  output logic [DATA_W-1:0]        dq_out,
  output logic                     dq_oe_n,
  output logic                     ce_n,
  output logic                     we_n,
  output logic                     oe_n,
  input  wire logic [DATA_W-1:0]   dq_in_sync
);
  import flash_host_pkg::*;

  bus_state_t              st_q, st_d;
  logic [ADDR_W-1:0]       a_d;
  logic [DATA_W-1:0]       do_q, do_d, rd_q, rd_d;
  logic                    dqoe_q, dqoe_d, ce_q, ce_d, we_q, we_d;
  logic                    oe_q, oe_d, done_q, done_d;
  logic [1:0]              rw_q, rw_d;
  // Read data is taken only after it has crossed both synchroniser stages.
  localparam logic [1:0]   RD_WAIT = 2'h2;

  always_comb
  begin
    st_d   = st_q;
    a_d    = addr_q;
    do_d   = do_q;
    rd_d   = rd_q;
    dqoe_d = dqoe_q;
    ce_d   = ce_q;
    we_d   = we_q;
    oe_d   = oe_q;
    done_d = 1'b0;
    rw_d   = 2'h0;
    case (st_q)
      BS_IDLE:
        if (req_wr)
        begin
          // Output enable is raised before any write strobe falls.
          a_d    = req_addr;
          do_d   = req_data;
          dqoe_d = 1'b0;
          oe_d   = 1'b1;
          st_d   = BS_SETUP;
        end
        else if (req_rd)
        begin
          a_d    = req_addr;
          dqoe_d = 1'b1;
          we_d   = 1'b1;
          st_d   = BS_RD;
        end
      BS_SETUP:
      begin
        ce_d = 1'b0;
        we_d = 1'b0;
        st_d = BS_LOW;
      end
      BS_LOW:
      begin
        // Both strobes rise together so data is held through the edge.
        ce_d = 1'b1;
        we_d = 1'b1;
        st_d = BS_HIGH;
      end
      BS_HIGH:
      begin
        dqoe_d = 1'b1;
        done_d = 1'b1;
        st_d   = BS_IDLE;
      end
      BS_RD:
      begin
        ce_d = 1'b0;
        oe_d = 1'b0;
        st_d = BS_RDS;
      end
      BS_RDS:
      begin
        // Two synchroniser stages plus access time need three cycles.
        rw_d = rw_q + 2'h1;
        if (rw_q == RD_WAIT)
        begin
          rw_d   = 2'h0;
          rd_d   = dq_in_sync;
          ce_d   = 1'b1;
          oe_d   = 1'b1;
          done_d = 1'b1;
          st_d   = BS_IDLE;
        end
      end
      default:
        st_d = BS_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      st_q   <= BS_IDLE;
      addr_q <= '0;
      do_q   <= '0;
      rd_q   <= '0;
      dqoe_q <= 1'b1;
      ce_q   <= 1'b1;
      we_q   <= 1'b1;
      oe_q   <= 1'b1;
      done_q <= 1'b0;
      rw_q   <= 2'h0;
    end
    else
    begin
      st_q   <= st_d;
      addr_q <= a_d;
      do_q   <= do_d;
      rd_q   <= rd_d;
      dqoe_q <= dqoe_d;
      ce_q   <= ce_d;
      we_q   <= we_d;
      oe_q   <= oe_d;
      done_q <= done_d;
      rw_q   <= rw_d;
    end
  end

  assign dq_out   = do_q;
  assign dq_oe_n  = dqoe_q;
  assign ce_n     = ce_q;
  assign we_n     = we_q;
  assign oe_n     = oe_q;
  assign cyc_done = done_q;
  assign rd_data  = rd_q;

endmodule : flash_bus_cycle

// ---- rtl/flash_host_ctrl.sv ----
/*
  Host controller for a byte-wide bulk-erase flash: programs single bytes
  and runs the full pre-zero, erase and verify algorithm over the pins.
  Assumes the high program voltage switch and supply are external; the
  controller only raises its enable request and waits for power_good.
*/
`timescale 1ns/1ns
module flash_host_ctrl
  import flash_host_pkg::*;
#(
  parameter logic [7:0]  CMD_READ    = CMD_READ_DEF,
  parameter logic [7:0]  CMD_ERASE   = CMD_ERASE_DEF,
  parameter logic [7:0]  CMD_EVERIFY = CMD_EVERIFY_DEF,
  parameter logic [7:0]  CMD_PROG    = CMD_PROG_DEF,
  parameter logic [7:0]  CMD_PVERIFY = CMD_PVERIFY_DEF,
  parameter int unsigned ERASE_WAIT  = ERASE_CYC,
  parameter int unsigned PROG_WAIT   = PROG_CYC,
  parameter int unsigned LAST_ADDR   = 16'hFFFF
)
(
  // Clock and reset
  input  wire logic                          ref_clk,
  input  wire logic                          rst,
  // User command port
  input  wire logic                          start_prog,
  input  wire logic                          start_erase,
  input  wire logic [flash_host_pkg::ADDR_W-1:0] user_addr,
  input  wire logic [flash_host_pkg::DATA_W-1:0] user_data,
  output logic                               busy,
  output logic                               done,
  output logic                               fail,
  // Power
  input  wire logic                          power_good,
  output logic                               vpp_en,
  // Flash pins
  output logic [flash_host_pkg::ADDR_W-1:0]  flash_addr,
  output logic [flash_host_pkg::DATA_W-1:0]  dq_out,
  output logic                               dq_oe_n,
  input  wire logic [flash_host_pkg::DATA_W-1:0] dq_in,
  output logic                               ce_n,
  output logic                               we_n,
  output logic                               oe_n
);
  import flash_host_pkg::*;

  localparam int unsigned WAIT_MAX = (ERASE_WAIT > PROG_WAIT) ?
                                     ERASE_WAIT : PROG_WAIT;
  localparam int unsigned TW = $clog2(WAIT_MAX + 1);

  seq_state_t              st_q, st_d;
  logic [ADDR_W-1:0]       a_q, a_d;
  logic [DATA_W-1:0]       ud_q, ud_d;
  logic [TW-1:0]           t_q, t_d;
  logic [9:0]              tries_q, tries_d;
  logic                    erase_q, erase_d;
  logic                    issued_q, issued_d;
  logic                    busy_q, busy_d, done_q, done_d, fail_q, fail_d;
  logic                    vpp_q, vpp_d, pg_s1, pg_s2;
  logic [DATA_W-1:0]       dq_s1, dq_s2;
  logic                    req_wr, cyc_done, rd_ph_q, rd_ph_d;
  logic                    rd_busy_q, rd_busy_d;
  logic [DATA_W-1:0]       wr_byte, rd_data;

  // Pins from the device pass two flip-flops before any logic reads them.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      pg_s1 <= 1'b0;
      pg_s2 <= 1'b0;
      dq_s1 <= '0;
      dq_s2 <= '0;
    end
    else
    begin
      pg_s1 <= power_good;
      pg_s2 <= pg_s1;
      dq_s1 <= dq_in;
      dq_s2 <= dq_s1;
    end
  end

  // Write data and write requests follow the sequencer state.
  always_comb
  begin
    req_wr  = 1'b0;
    wr_byte = ZERO_BYTE;
    if (!issued_q && pg_s2)
    begin
      case (st_q)
        ST_ESETUP, ST_ESTART:
        begin
          req_wr  = 1'b1;
          wr_byte = CMD_ERASE;
        end
        ST_ZPROG, ST_PSETUP:
        begin
          req_wr  = 1'b1;
          wr_byte = CMD_PROG;
        end
        ST_PSTART:
        begin
          req_wr  = 1'b1;
          wr_byte = erase_q ? ZERO_BYTE : ud_q;
        end
        ST_EVERIFY:
        begin
          req_wr  = 1'b1;
          wr_byte = CMD_EVERIFY;
        end
        ST_PVERIFY:
        begin
          req_wr  = 1'b1;
          wr_byte = CMD_PVERIFY;
        end
        default:
          req_wr = 1'b0;
      endcase
    end
  end

  always_comb
  begin
    st_d     = st_q;
    a_d      = a_q;
    ud_d     = ud_q;
    t_d      = t_q;
    tries_d  = tries_q;
    erase_d  = erase_q;
    issued_d = issued_q;
    busy_d   = busy_q;
    done_d   = 1'b0;
    fail_d   = 1'b0;
    vpp_d    = vpp_q;
    if (req_wr)
      issued_d = 1'b1;
    case (st_q)
      ST_IDLE:
      begin
        vpp_d = 1'b0;
        // Strobes stay idle until the supply is good.
        if (pg_s2 && (start_prog || start_erase))
        begin
          busy_d   = 1'b1;
          vpp_d    = 1'b1;
          erase_d  = start_erase;
          ud_d     = user_data;
          a_d      = start_erase ? '0 : user_addr;
          tries_d  = '0;
          issued_d = 1'b0;
          st_d     = start_erase ? ST_ZPROG : ST_PSETUP;
        end
      end
      ST_ZPROG, ST_PSETUP, ST_ESETUP:
        if (issued_q && cyc_done)
        begin
          issued_d = 1'b0;
          st_d = (st_q == ST_ESETUP) ? ST_ESTART : ST_PSTART;
        end
      ST_PSTART, ST_ESTART:
        if (issued_q && cyc_done)
        begin
          issued_d = 1'b0;
          t_d  = (st_q == ST_ESTART) ? TW'(ERASE_WAIT) : TW'(PROG_WAIT);
          st_d = (st_q == ST_ESTART) ? ST_EWAIT : ST_PWAIT;
        end
      ST_EWAIT, ST_PWAIT:
        if (t_q > TW'(1))
          t_d = t_q - TW'(1);
        else
          st_d = (st_q == ST_EWAIT) ? ST_EVERIFY : ST_PVERIFY;
      ST_EVERIFY, ST_PVERIFY:
        if (issued_q && cyc_done && rd_ph_q)
        begin
          issued_d = 1'b0;
          if (st_q == ST_EVERIFY)
          begin
            if (rd_data != ERASED_BYTE)
            begin
              tries_d = tries_q + 10'd1;
              st_d = (tries_q + 10'd1 >= 10'(ERASE_MAX_TRIES)) ?
                     ST_FAIL : ST_ESETUP;
            end
            else if (a_q == ADDR_W'(LAST_ADDR))
              st_d = ST_DONE;
            else
              a_d = a_q + ADDR_W'(1);
          end
          else if (rd_data != (erase_q ? ZERO_BYTE : ud_q))
          begin
            tries_d = tries_q + 10'd1;
            st_d = (tries_q + 10'd1 >= 10'(PROG_MAX_TRIES)) ?
                   ST_FAIL : ST_PSETUP;
          end
          else if (erase_q && a_q != ADDR_W'(LAST_ADDR))
          begin
            a_d     = a_q + ADDR_W'(1);
            tries_d = '0;
            st_d    = ST_PSETUP;
          end
          else if (erase_q)
          begin
            a_d     = '0;
            tries_d = '0;
            st_d    = ST_ESETUP;
          end
          else
            st_d = ST_DONE;
        end
      ST_DONE, ST_FAIL:
      begin
        done_d = (st_q == ST_DONE);
        fail_d = (st_q == ST_FAIL);
        busy_d = 1'b0;
        vpp_d  = 1'b0;
        st_d   = ST_IDLE;
      end
      default:
        st_d = ST_IDLE;
    endcase
    // Loss of supply aborts once the bus cycle in flight has ended, so no
    // write strobe is ever low after the program voltage request drops.
    if (!pg_s2 && !rd_busy_q && st_q != ST_IDLE && st_q != ST_DONE &&
        st_q != ST_FAIL)
    begin
      st_d   = ST_FAIL;
      vpp_d  = 1'b0;
    end
  end

  // Verify is a write then a read; the phase bit picks the read.
  always_comb
  begin
    rd_ph_d = rd_ph_q;
    if (st_q != ST_EVERIFY && st_q != ST_PVERIFY)
      rd_ph_d = 1'b0;
    else if (cyc_done)
      rd_ph_d = ~rd_ph_q;
  end
  wire verify_rd = (st_q == ST_EVERIFY || st_q == ST_PVERIFY) && pg_s2 &&
                   issued_q && rd_ph_q && !cyc_done && !rd_busy_q;
  // The busy bit covers every bus cycle in flight, writes as well as reads.
  always_comb
  begin
    rd_busy_d = rd_busy_q;
    if (verify_rd || req_wr)
      rd_busy_d = 1'b1;
    else if (cyc_done)
      rd_busy_d = 1'b0;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      st_q      <= ST_IDLE;
      a_q       <= '0;
      ud_q      <= '0;
      t_q       <= '0;
      tries_q   <= '0;
      erase_q   <= 1'b0;
      issued_q  <= 1'b0;
      busy_q    <= 1'b0;
      done_q    <= 1'b0;
      fail_q    <= 1'b0;
      vpp_q     <= 1'b0;
      rd_ph_q   <= 1'b0;
      rd_busy_q <= 1'b0;
    end
    else
    begin
      st_q      <= st_d;
      a_q       <= a_d;
      ud_q      <= ud_d;
      t_q       <= t_d;
      tries_q   <= tries_d;
      erase_q   <= erase_d;
      issued_q  <= issued_d;
      busy_q    <= busy_d;
      done_q    <= done_d;
      fail_q    <= fail_d;
      vpp_q     <= vpp_d;
      rd_ph_q   <= rd_ph_d;
      rd_busy_q <= rd_busy_d;
    end
  end

  flash_bus_cycle u_cycle (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .req_wr     (req_wr),
    .req_rd     (verify_rd),
    .req_addr   (a_q),
    .req_data   (wr_byte),
    .cyc_done   (cyc_done),
    .rd_data    (rd_data),
    .addr_q     (flash_addr),
    .dq_out     (dq_out),
    .dq_oe_n    (dq_oe_n),
    .ce_n       (ce_n),
    .we_n       (we_n),
    .oe_n       (oe_n),
    .dq_in_sync (dq_s2)
  );

  assign busy   = busy_q;
  assign done   = done_q;
  assign fail   = fail_q;
  assign vpp_en = vpp_q;

endmodule : flash_host_ctrl

// ---- rtl/flash_host_pkg.sv ----
/*
  Constants shared by the flash host controller: command byte defaults,
  timing figures and derived cycle counts, retry limits, state encodings.
  Assumes a 10 MHz reference clock.
*/
package flash_host_pkg;

  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned ADDR_W          = 16;
  localparam int unsigned DATA_W          = 8;

  // Command bytes are configurable; these defaults are arbitrary.
  localparam logic [7:0]  CMD_READ_DEF    = 8'h00;
  localparam logic [7:0]  CMD_ERASE_DEF   = 8'h20;
  localparam logic [7:0]  CMD_EVERIFY_DEF = 8'hA0;
  localparam logic [7:0]  CMD_PROG_DEF    = 8'h40;
  localparam logic [7:0]  CMD_PVERIFY_DEF = 8'hC0;

  localparam logic [7:0]  ERASED_BYTE     = 8'hFF;
  localparam logic [7:0]  ZERO_BYTE       = 8'h00;

  // Pulse widths in their own units, then as whole clock cycles.
  localparam int unsigned ERASE_PULSE_MS  = 10;
  localparam int unsigned PROG_PULSE_US   = 10;
  localparam int unsigned ERASE_CYC =
    (ERASE_PULSE_MS * (CLK_HZ / 1000) < 1) ? 1 :
    ERASE_PULSE_MS * (CLK_HZ / 1000);
  localparam int unsigned PROG_CYC =
    (PROG_PULSE_US * (CLK_HZ / 1_000_000) < 1) ? 1 :
    PROG_PULSE_US * (CLK_HZ / 1_000_000);

  // Strobe low width; glitches shorter than 10 ns are rejected, so
  // one full 100 ns phase per step keeps every strobe well clear.
  localparam int unsigned STROBE_NS       = 100;
  localparam int unsigned STROBE_CYC      = 1;

  localparam int unsigned ERASE_MAX_TRIES = 1000;
  localparam int unsigned PROG_MAX_TRIES  = 25;

  typedef enum logic [3:0] {
    ST_IDLE    = 4'b0000,
    ST_ZPROG   = 4'b0001,
    ST_ESETUP  = 4'b0010,
    ST_ESTART  = 4'b0011,
    ST_EWAIT   = 4'b0100,
    ST_EVERIFY = 4'b0101,
    ST_PSETUP  = 4'b0110,
    ST_PSTART  = 4'b0111,
    ST_PWAIT   = 4'b1000,
    ST_PVERIFY = 4'b1001,
    ST_DONE    = 4'b1010,
    ST_FAIL    = 4'b1011
  } seq_state_t;

  typedef enum logic [2:0] {
    BS_IDLE  = 3'b000,
    BS_SETUP = 3'b001,
    BS_LOW   = 3'b010,
    BS_HIGH  = 3'b011,
    BS_RD    = 3'b100,
    BS_RDS   = 3'b101
  } bus_state_t;

endpackage : flash_host_pkg

// ---- test/flash_dev_model.sv ----
/*
  Behavioural model of the byte-wide bulk-erase flash on the far side of
  the host controller: command register, four-byte array, pulse timers.
  Assumes the bench resolves the data pins and ties vcc_ok to power_good.
*/
`timescale 1ns/1ns
module flash_dev_model
  import flash_host_pkg::*;
#(
  parameter logic [7:0] CMD_ERASE   = CMD_ERASE_DEF,
  parameter logic [7:0] CMD_EVERIFY = CMD_EVERIFY_DEF,
  parameter logic [7:0] CMD_PROG    = CMD_PROG_DEF,
  parameter logic [7:0] CMD_PVERIFY = CMD_PVERIFY_DEF,
  parameter int         ERASE_NS    = 2000,
  parameter int         PROG_NS     = 500,
  parameter int         GLITCH_NS   = 10
)
(
  // Supplies
  input  wire logic              vpp_hi,
  input  wire logic              vcc_ok,
  // Bus pins
  input  wire logic              ce_n,
  input  wire logic              we_n,
  input  wire logic              oe_n,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] dq_wr,
  output logic [DATA_W-1:0]      dq_rd,
  // Fault knobs and observation
  input  wire logic              bad_en,
  input  wire logic [1:0]        bad_addr,
  input  wire logic              weak_en,
  output logic [31:0]            mem_flat,
  output logic [15:0]            n_pgm,
  output logic [15:0]            n_ers,
  output logic [15:0]            n_viol
);
  typedef enum logic [2:0] {M_READ, M_ESET, M_ERS, M_EVER, M_PSET, M_PGM,
                            M_PVER} mode_t;
  logic [7:0]        mem [4] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF};
  mode_t             mode      = M_READ;
  logic              wr_act    = 1'b0;
  logic              zero_due  = 1'b1;
  logic              weak_used = 1'b0;
  logic [1:0]        wa        = 2'b00;
  logic [1:0]        ra        = 2'b00;
  logic [7:0]        last_out  = 8'h00;
  logic [7:0]        cur;
  time               t_fall;
  time               t_pulse;

  initial
  begin
    n_pgm  = '0;
    n_ers  = '0;
    n_viol = '0;
  end

  assign mem_flat = {mem[3], mem[2], mem[1], mem[0]};
  assign cur      = (mode == M_READ) ? mem[addr[1:0]] : mem[ra];
  // Released pins show the inverse, so a host sampling them late fails.
  assign dq_rd    = (!ce_n && !oe_n) ? cur : ~last_out;

  always @(posedge oe_n or posedge ce_n)
    last_out = cur;

  // The later falling strobe opens the write and latches the address.
  always @(negedge ce_n or negedge we_n)
  begin
    if (!ce_n && !we_n && oe_n)
    begin
      wr_act = 1'b1;
      wa     = addr[1:0];
      t_fall = $time;
    end
    if (!ce_n && !we_n && !oe_n)
      n_viol = n_viol + 16'h0001;
  end

  // The earlier rising strobe takes the data.
  always @(posedge ce_n or posedge we_n)
    if (wr_act)
    begin
      wr_act = 1'b0;
      if ($time - t_fall >= GLITCH_NS && vpp_hi && vcc_ok)
        take(dq_wr);
    end

  always @(negedge vcc_ok)
    mode = M_READ;

  // Pulses are applied at once; the next verify command ends them and checks their length.
  task automatic take(input logic [7:0] d);
    if (mode == M_PSET)
    begin
      if (!(bad_en && wa == bad_addr))
        mem[wa] = mem[wa] & d;
      n_pgm    = n_pgm + 16'h0001;
      zero_due = 1'b1;
      t_pulse  = $time;
      mode     = M_PGM;
    end
    else if (d == CMD_ERASE && mode == M_ESET)
    begin
      if (zero_due)
        foreach (mem[i])
          if (mem[i] != 8'h00)
            n_viol = n_viol + 16'h0001;
      foreach (mem[i])
        mem[i] = (weak_en && !weak_used && i == 0) ? 8'h0F : 8'hFF;
      weak_used = weak_en;
      zero_due  = 1'b0;
      n_ers     = n_ers + 16'h0001;
      t_pulse   = $time;
      mode      = M_ERS;
    end
    else if (d == CMD_ERASE)
      mode = M_ESET;
    else if (d == CMD_EVERIFY)
    begin
      if (mode == M_ERS && $time - t_pulse < ERASE_NS)
        n_viol = n_viol + 16'h0001;
      ra   = wa;
      mode = M_EVER;
    end
    else if (d == CMD_PROG)
      mode = M_PSET;
    else if (d == CMD_PVERIFY)
    begin
      if (mode == M_PGM && $time - t_pulse < PROG_NS)
        n_viol = n_viol + 16'h0001;
      ra   = wa;
      mode = M_PVER;
    end
    else
      mode = M_READ;
  endtask : take
endmodule : flash_dev_model

// ---- test/flash_host_ctrl_asserts.sv ----
/*
  Concurrent checks on the flash pins of the host controller.
  Assumes binding to flash_host_ctrl and a single reference clock.
*/
`timescale 1ns/1ns
module flash_host_ctrl_asserts
  import flash_host_pkg::*;
#(
  parameter logic [7:0]  CMD_ERASE   = CMD_ERASE_DEF,
  parameter logic [7:0]  CMD_EVERIFY = CMD_EVERIFY_DEF,
  parameter logic [7:0]  CMD_PVERIFY = CMD_PVERIFY_DEF,
  parameter int unsigned ERASE_WAIT  = ERASE_CYC,
  parameter int unsigned PROG_WAIT   = PROG_CYC
)
(
  input wire logic              ref_clk,
  input wire logic              rst,
  input wire logic              busy,
  input wire logic              done,
  input wire logic              fail,
  input wire logic              vpp_en,
  input wire logic [ADDR_W-1:0] flash_addr,
  input wire logic [DATA_W-1:0] dq_out,
  input wire logic              dq_oe_n,
  input wire logic              ce_n,
  input wire logic              we_n,
  input wire logic              oe_n
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  logic [31:0] gap_q, gap_d;
  logic [7:0]  last_q, last_d;
  logic        we_q;

  // Gap counts cycles since the last write ended; it saturates.
  always_comb
  begin
    gap_d  = (gap_q < 32'h000F_FFFF) ? gap_q + 32'h0000_0001 : gap_q;
    last_d = last_q;
    if (we_n && !we_q)
    begin
      gap_d  = 32'h0000_0000;
      last_d = dq_out;
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      gap_q  <= 32'h0000_0000;
      last_q <= 8'h00;
      we_q   <= 1'b1;
    end
    else
    begin
      gap_q  <= gap_d;
      last_q <= last_d;
      we_q   <= we_n;
    end

  sequence verify_fall(logic [7:0] cmd);
    $fell(we_n) && dq_out == cmd;
  endsequence
  sequence write_pulse;
    !we_n ##1 we_n;
  endsequence

  a_write_oe_high: assert property (!we_n |-> oe_n && !ce_n)
    else $error("write strobe low with output enable low");
  a_write_vpp_on: assert property (!we_n |-> vpp_en && busy)
    else $error("write without program voltage request");
  a_write_data_held: assert property (!we_n |=> !dq_oe_n &&
    $stable(dq_out) && $stable(flash_addr))
    else $error("address or data moved during write");
  a_strobe_single: assert property ($fell(we_n) |-> write_pulse)
    else $error("write strobe not one clean cycle");
  a_read_no_drive: assert property (!oe_n |-> dq_oe_n && we_n)
    else $error("host drives data during read");
  a_prog_wait: assert property (verify_fall(CMD_PVERIFY) |->
    gap_q >= PROG_WAIT)
    else $error("program verify too early");
  a_erase_wait: assert property (verify_fall(CMD_EVERIFY) ##0
    last_q == CMD_ERASE |-> gap_q >= ERASE_WAIT)
    else $error("erase verify too early");
  a_idle_quiet: assert property (!busy && !done && !fail |->
    we_n && ce_n)
    else $error("strobe active while idle");
  a_end_pulse: assert property (done || fail |=> !done && !fail)
    else $error("done or fail longer than one cycle");
endmodule : flash_host_ctrl_asserts

bind flash_host_ctrl flash_host_ctrl_asserts #(
  .CMD_ERASE   (CMD_ERASE),
  .CMD_EVERIFY (CMD_EVERIFY),
  .CMD_PVERIFY (CMD_PVERIFY),
  .ERASE_WAIT  (ERASE_WAIT),
  .PROG_WAIT   (PROG_WAIT)
) flash_host_ctrl_asserts_inst (
  .ref_clk(ref_clk), .rst(rst), .busy(busy), .done(done), .fail(fail),
  .vpp_en(vpp_en), .flash_addr(flash_addr), .dq_out(dq_out),
  .dq_oe_n(dq_oe_n), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n)
);

// ---- test/flash_host_ctrl_test.sv ----
/*
  Self-checking bench for the flash host controller against the device
  model. Assumes shortened waits: erase 20, program 5, last address 3.
*/
`timescale 1ns/1ns
module flash_host_ctrl_test;
  import flash_host_pkg::*;
  localparam int unsigned EW = 20;
  localparam int unsigned PW = 5;
  logic              ref_clk, rst, start_prog, start_erase, power_good;
  logic              busy, done, fail, vpp_en, dq_oe_n, ce_n, we_n, oe_n;
  logic              bad_en, weak_en;
  logic [1:0]        bad_addr;
  logic [ADDR_W-1:0] user_addr, flash_addr;
  logic [DATA_W-1:0] user_data, dq_out, dq_in, dq_rd;
  logic [31:0]       mem_flat;
  logic [15:0]       n_pgm, n_ers, n_viol, p0, e0;
  int                mismatches, n_tests, cycles;

  assign dq_in = dq_oe_n ? dq_rd : dq_out;

  flash_host_ctrl #(.ERASE_WAIT(EW), .PROG_WAIT(PW), .LAST_ADDR(3))
  flash_host_ctrl_inst (.ref_clk(ref_clk), .rst(rst),
    .start_prog(start_prog), .start_erase(start_erase),
    .user_addr(user_addr), .user_data(user_data), .busy(busy),
    .done(done), .fail(fail), .power_good(power_good), .vpp_en(vpp_en),
    .flash_addr(flash_addr), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
    .dq_in(dq_in), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n));

  flash_dev_model #(.ERASE_NS(EW * 100), .PROG_NS(PW * 100))
  flash_dev_model_inst (.vpp_hi(vpp_en), .vcc_ok(power_good), .ce_n(ce_n),
    .we_n(we_n), .oe_n(oe_n), .addr(flash_addr), .dq_wr(dq_in),
    .dq_rd(dq_rd), .bad_en(bad_en), .bad_addr(bad_addr),
    .weak_en(weak_en), .mem_flat(mem_flat), .n_pgm(n_pgm), .n_ers(n_ers),
    .n_viol(n_viol));

  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task bad(input string m);
    mismatches++;
    $display("mismatch at %0t: %s", $time, m);
  endtask : bad

  task conclude;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  // Bounded wait, so a stuck sequence ends in a mismatch.
  task wait_end(input int lim);
    int i;
    i = 0;
    while (done !== 1'b1 && fail !== 1'b1 && i < lim)
    begin
      @(negedge ref_clk);
      i++;
    end
  endtask : wait_end

  task kick(input bit er, input logic [15:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    start_prog  = !er;
    start_erase = er;
    user_addr   = a;
    user_data   = d;
    @(negedge ref_clk);
    start_prog  = 1'b0;
    start_erase = 1'b0;
    p0          = n_pgm;
    e0          = n_ers;
  endtask : kick

  task t_reset;
    n_tests += 3;
    if ({we_n, ce_n, oe_n, dq_oe_n} !== 4'hF) bad("strobes after reset");
    if (vpp_en !== 1'b0) bad("program voltage after reset");
    if (busy !== 1'b0) bad("busy after reset");
  endtask : t_reset

  task t_prog;
    kick(1'b0, 16'h0002, 8'h5A);
    @(negedge ref_clk);
    start_prog = 1'b1;
    @(negedge ref_clk);
    start_prog = 1'b0;
    wait_end(2000);
    n_tests += 3;
    if (done !== 1'b1) bad("program not done");
    if (mem_flat[23:16] !== 8'h5A) bad("programmed byte wrong");
    if (n_pgm !== p0 + 16'h0001) bad("repeat start not refused");
  endtask : t_prog

  task t_pfail;
    bad_en   = 1'b1;
    bad_addr = 2'b01;
    kick(1'b0, 16'h0001, 8'h33);
    wait_end(5000);
    n_tests += 2;
    if (fail !== 1'b1) bad("stuck byte not failed");
    if (n_pgm !== p0 + PROG_MAX_TRIES) bad("program retry count");
    bad_en = 1'b0;
  endtask : t_pfail

  task t_erase;
    weak_en = 1'b1;
    kick(1'b1, 16'h0000, 8'h00);
    wait_end(20000);
    n_tests += 4;
    if (done !== 1'b1) bad("erase not done");
    if (mem_flat !== 32'hFFFF_FFFF) bad("array not erased");
    if (n_ers !== e0 + 16'h0002) bad("erase retry count");
    if (n_pgm !== p0 + 16'h0004) bad("zero program count");
  endtask : t_erase

  // Losing power mid-erase must abort before any erase pulse.
  task t_abort;
    kick(1'b1, 16'h0000, 8'h00);
    repeat (40) @(negedge ref_clk);
    power_good = 1'b0;
    wait_end(200);
    n_tests += 2;
    if (fail !== 1'b1) bad("power loss not failed");
    if (n_ers !== e0) bad("erase after power loss");
    power_good = 1'b1;
    repeat (4) @(negedge ref_clk);
  endtask : t_abort

  initial
  begin
    cycles = 0;
    forever
    begin
      @(posedge ref_clk);
      cycles++;
      if (cycles == 60000)
      begin
        bad("timeout");
        conclude();
      end
    end
  end

  initial
  begin
    mismatches  = 0;
    n_tests     = 0;
    rst         = 1'b1;
    start_prog  = 1'b0;
    start_erase = 1'b0;
    user_addr   = 16'h0000;
    user_data   = 8'h00;
    power_good  = 1'b1;
    bad_en      = 1'b0;
    bad_addr    = 2'b00;
    weak_en     = 1'b0;
    repeat (2) @(negedge ref_clk);
    rst = 1'b0;
    repeat (3) @(negedge ref_clk);
    t_reset();
    t_prog();
    t_pfail();
    t_erase();
    t_abort();
    n_tests += 1;
    if (n_viol !== 16'h0000) bad("device saw host timing or order fault");
    conclude();
  end
endmodule : flash_host_ctrl_test
